// ==== msrc_consts.vh ====
// constants for the macro service ring counter engine
`ifndef MSRC_CONSTS_VH
`define MSRC_CONSTS_VH
// mode word bit positions; 3CH must read as combined, add, ring, irq
`define MSRC_MODE_INT_BIT 3
`define MSRC_MODE_RING_BIT 4
`define MSRC_MODE_ADD_BIT 2
`define MSRC_MODE_TW_BIT 0
`define MSRC_MODE_DINC_BIT 1
`define MSRC_MODE_TUPD_BIT 6
`define MSRC_MODE_CTYPE_BIT 5
// documented combined-transfer mode words
`define MSRC_MODE_INC_2B 8'h7F
`define MSRC_MODE_HOLD_1B 8'h3C
// channel area bases
`define MSRC_CHAN_BASE 20'h0_FE00
`define MSRC_RELOC_OFS 20'hF_0000
// hold-off after deferring instructions
`define MSRC_HOLD_CYC 4'h8
// instruction class codes on the decode port
`define MSRC_IC_OTHER 5'h00
`define MSRC_IC_EI_DI 5'h01
`define MSRC_IC_BRK 5'h02
`define MSRC_IC_RET_INT 5'h03
`define MSRC_IC_LOCATION 5'h04
`define MSRC_IC_PSW_POP 5'h05
`define MSRC_IC_PSW_MOV 5'h06
`define MSRC_IC_SP_IMM 5'h07
`define MSRC_IC_ICR_WR 5'h08
`define MSRC_IC_ICR_BT 5'h09
`define MSRC_IC_PSW_BIT 5'h0A
`define MSRC_IC_PSW_BT 5'h0B
`define MSRC_IC_CY_BIT 5'h0C
`define MSRC_IC_SOFT_INT 5'h0D
`define MSRC_IC_BLOCK 5'h0E
`define MSRC_IC_SAD 5'h0F
`endif

// ==== msrc_buf2.v ====
// two-entry valid/ready buffer on the output data path
`timescale 1ns/10ps
`default_nettype none
module msrc_buf2 #(
   parameter W = 16
) (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // fill side
   input wire in_valid,
   output wire in_ready,
   input wire [W-1:0] in_data,
   // drain side
   output wire out_valid,
   input wire out_ready,
   output wire [W-1:0] out_data
);
   reg [W-1:0] mem_q [0:1];
   reg wp_q;
   reg rp_q;
   reg [1:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;
   assign in_ready = (cnt_q != 2'd2);
   assign out_valid = (cnt_q != 2'd0);
   assign out_data = mem_q[rp_q];
   // pointers and fill level; a full buffer stalls the source
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         wp_q <= 1'b0;
         rp_q <= 1'b0;
         cnt_q <= 2'd0;
         mem_q[0] <= {W{1'b0}};
         mem_q[1] <= {W{1'b0}};
      end else begin
         if (push) begin
            mem_q[wp_q] <= in_data;
            wp_q <= ~wp_q;
         end
         if (pop)
            rp_q <= ~rp_q;
         if (push && !pop)
            cnt_q <= cnt_q + 2'd1;
         else if (pop && !push)
            cnt_q <= cnt_q - 2'd1;
      end
   end
endmodule // msrc_buf2
`default_nettype wire

// ==== msrc_engine.v ====
// macro service engine: combined transfer, ring control, counter mode
// Overview of operation
// - auto add: compare plus delta written back
// - no auto add: fetched value copied
// - ring table repeats one cycle in order
// - ring counter zero: rewind pointer, reload counter
// - count decremented on every transfer
// - interrupt at count zero despite ring
// - at zero clear mode bit, vector or flag
// - mode 7FH: increment both, two-byte, add, ring
// - mode 3CH: timer held, data down, one-byte
// - counter mode only decrements the count
// - counter channel is one 16-bit count word
// - relocation adds 0F0000H to channel address
// - deferring instruction holds off service 8 clocks
// - software interrupts never held off
// - deferring set of instruction classes
// - status word bit ops defer, with exceptions
// - block instructions suspend then resume
`timescale 1ns/10ps
`default_nettype none
`include "msrc_consts.vh"
module msrc_engine #(
   parameter AW = 20,
   parameter DW = 16
) (
   // clock and reset
   input wire mclk,
   input wire rst_n,
   // channel setup, loaded by start_load
   input wire start_load,
   input wire [7:0] mode_word,
   input wire [7:0] channel_pointer,
   input wire [AW-1:0] timer_data_pointer_init,
   input wire [AW-1:0] pattern_data_pointer_init,
   input wire [15:0] transfer_count_init,
   input wire [7:0] ring_length_reg,
   input wire [7:0] ring_step_init,
   input wire [7:0] timer_target_pointer,
   input wire [7:0] pattern_target_pointer,
   input wire relocate_high,
   // service request from an interrupt source
   input wire service_req,
   output wire service_busy,
   // memory read port, data valid one cycle after strobe
   output reg mem_rd,
   output reg [AW-1:0] mem_addr,
   input wire [DW-1:0] mem_rdata,
   // compare register
   input wire [DW-1:0] timer_compare_value,
   output reg cmp_wr,
   output reg [DW-1:0] cmp_wdata,
   output reg [7:0] cmp_target,
   // pattern stream toward the realtime output buffer
   output wire pat_valid,
   input wire pat_ready,
   output wire [7:0] pat_data,
   output reg [7:0] pat_target,
   // completion
   output reg transfer_service_mode_bit,
   output reg vectored_irq,
   output reg request_flag_clr,
   output reg [AW-1:0] channel_addr,
   // cpu instruction stream
   input wire instr_done,
   input wire [4:0] instr_class,
   input wire soft_int_req,
   input wire irq_pending,
   output wire irq_ack_ok,
   output wire soft_int_ok,
   output wire block_suspend,
   output reg block_resume,
   // channel state visible to software
   output wire [15:0] transfer_count,
   output wire [7:0] ring_step_counter,
   output wire [AW-1:0] timer_data_ptr_now,
   output wire [AW-1:0] pattern_data_ptr_now
);
   localparam S_IDLE = 3'd0;
   localparam S_TRD = 3'd1;
   localparam S_TWR = 3'd2;
   localparam S_DRD = 3'd3;
   localparam S_DWR = 3'd4;
   localparam S_CNT = 3'd5;
   localparam [3:0] HOLD_N = `MSRC_HOLD_CYC;

   reg [2:0] st_q;
   reg [7:0] mode_q;
   reg [AW-1:0] tptr_q;
   reg [AW-1:0] dptr_q;
   reg [15:0] cnt_q;
   reg [7:0] ring_q;
   reg [7:0] rlen_q;
   reg [3:0] hold_q;
   reg blk_q;
   reg buf_vld;
   reg [7:0] buf_dat;
   wire buf_rdy;
   wire [15:0] pat_word;

   // mode word fields; 7FH and 3CH decode through these bits
   wire m_int = mode_q[`MSRC_MODE_INT_BIT];
   wire m_ring = mode_q[`MSRC_MODE_RING_BIT];
   wire m_add = mode_q[`MSRC_MODE_ADD_BIT];
   wire m_tw = mode_q[`MSRC_MODE_TW_BIT];
   wire m_dinc = mode_q[`MSRC_MODE_DINC_BIT];
   wire m_tupd = mode_q[`MSRC_MODE_TUPD_BIT];
   wire m_ctype = mode_q[`MSRC_MODE_CTYPE_BIT];

   // step a pointer up or down by a size of one or two bytes
   function [AW-1:0] step_ptr;
      input [AW-1:0] p;
      input up;
      input two;
      reg [AW-1:0] s;
      begin
         s = two ? {{(AW-2){1'b0}}, 2'd2} : {{(AW-1){1'b0}}, 1'b1};
         step_ptr = up ? p + s : p - s;
      end
   endfunction

   // deferring instruction classes
   function defers;
      input [4:0] c;
      begin
         case (c)
            `MSRC_IC_EI_DI, `MSRC_IC_BRK, `MSRC_IC_RET_INT,
            `MSRC_IC_LOCATION, `MSRC_IC_PSW_POP, `MSRC_IC_PSW_MOV,
            `MSRC_IC_SP_IMM, `MSRC_IC_ICR_WR,
            `MSRC_IC_PSW_BIT: defers = 1'b1;
            default: defers = 1'b0; // bit tests and carry ops pass
         endcase
      end
   endfunction

   wire holding = (hold_q != 4'd0);
   assign irq_ack_ok = !holding && (st_q == S_IDLE);
   assign soft_int_ok = soft_int_req;
   assign service_busy = (st_q != S_IDLE) || holding;
   assign block_suspend = blk_q && (irq_pending || service_req)
      && irq_ack_ok;
   assign transfer_count = cnt_q;
   assign ring_step_counter = ring_q;
   assign timer_data_ptr_now = tptr_q;
   assign pattern_data_ptr_now = dptr_q;

   // hold-off counter restarts on each deferring instruction
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         hold_q <= 4'd0;
      else if (instr_done && defers(instr_class))
         hold_q <= HOLD_N;
      else if (holding)
         hold_q <= hold_q - 4'd1;
   end

   // block instruction in flight; resume once service is over
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         blk_q <= 1'b0;
         block_resume <= 1'b0;
      end else begin
         block_resume <= 1'b0;
         if (instr_done && (instr_class == `MSRC_IC_BLOCK ||
               instr_class == `MSRC_IC_SAD))
            blk_q <= 1'b1;
         else if (instr_done)
            blk_q <= 1'b0;
         if (blk_q && st_q == S_CNT)
            block_resume <= 1'b1;
      end
   end

   // channel address, high relocation adds the fixed offset
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n)
         channel_addr <= {AW{1'b0}};
      else if (start_load)
         channel_addr <= `MSRC_CHAN_BASE + {12'h000, channel_pointer} +
            (relocate_high ? `MSRC_RELOC_OFS : 20'h0_0000);
   end

   // service sequencer
   always @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= S_IDLE;
         mode_q <= 8'h00;
         tptr_q <= {AW{1'b0}};
         dptr_q <= {AW{1'b0}};
         cnt_q <= 16'h0000;
         ring_q <= 8'h00;
         rlen_q <= 8'h00;
         mem_rd <= 1'b0;
         mem_addr <= {AW{1'b0}};
         cmp_wr <= 1'b0;
         cmp_wdata <= {DW{1'b0}};
         cmp_target <= 8'h00;
         pat_target <= 8'h00;
         buf_vld <= 1'b0;
         buf_dat <= 8'h00;
         transfer_service_mode_bit <= 1'b0;
         vectored_irq <= 1'b0;
         request_flag_clr <= 1'b0;
      end else begin
         mem_rd <= 1'b0;
         cmp_wr <= 1'b0;
         vectored_irq <= 1'b0;
         request_flag_clr <= 1'b0;
         if (buf_vld && buf_rdy)
            buf_vld <= 1'b0;
         case (st_q)
            S_IDLE: begin
               if (start_load) begin
                  mode_q <= mode_word;
                  tptr_q <= timer_data_pointer_init;
                  dptr_q <= pattern_data_pointer_init;
                  cnt_q <= transfer_count_init;
                  rlen_q <= ring_length_reg;
                  ring_q <= ring_step_init;
                  cmp_target <= timer_target_pointer;
                  pat_target <= pattern_target_pointer;
                  transfer_service_mode_bit <= 1'b1;
               end else if (service_req && transfer_service_mode_bit &&
                     !holding) begin
                  if (!m_ctype) begin
                     st_q <= S_CNT; // no data moved
                  end else begin
                     mem_rd <= 1'b1;
                     mem_addr <= tptr_q;
                     st_q <= S_TRD;
                  end
               end
            end
            S_TRD: st_q <= S_TWR;
            S_TWR: begin
               // delta added or copied into the compare register
               cmp_wr <= 1'b1;
               if (m_add)
                  cmp_wdata <= timer_compare_value +
                     (m_tw ? mem_rdata : {8'h00, mem_rdata[7:0]});
               else
                  cmp_wdata <= m_tw ? mem_rdata :
                     {8'h00, mem_rdata[7:0]};
               if (m_tupd)
                  tptr_q <= step_ptr(tptr_q, m_dinc, m_tw);
               mem_rd <= 1'b1;
               mem_addr <= dptr_q;
               st_q <= S_DRD;
            end
            S_DRD: st_q <= S_DWR;
            S_DWR: begin
               // wait for buffer space so no pattern is lost
               if (!buf_vld || buf_rdy) begin
                  buf_vld <= 1'b1;
                  buf_dat <= mem_rdata[7:0];
                  if (m_ring && ring_q <= 8'd1) begin
                     // wrap to the first pattern
                     dptr_q <= m_dinc ? dptr_q - {12'h000, rlen_q} +
                        {{(AW-1){1'b0}}, 1'b1} :
                        dptr_q + {12'h000, rlen_q} -
                        {{(AW-1){1'b0}}, 1'b1};
                     ring_q <= rlen_q;
                  end else begin
                     dptr_q <= step_ptr(dptr_q, m_dinc, 1'b0);
                     if (m_ring)
                        ring_q <= ring_q - 8'd1;
                  end
                  st_q <= S_CNT;
               end
            end
            S_CNT: begin
               cnt_q <= cnt_q - 16'h0001;
               if (cnt_q == 16'h0001) begin
                  transfer_service_mode_bit <= 1'b0;
                  if (m_int || !m_ctype)
                     vectored_irq <= 1'b1;
                  else
                     request_flag_clr <= 1'b1;
               end
               st_q <= S_IDLE;
            end
            default: st_q <= S_IDLE;
         endcase
      end
   end

   // pattern path through a two-entry buffer
   msrc_buf2 #(
      .W(16)
   ) u_buf (
      .mclk(mclk),
      .rst_n(rst_n),
      .in_valid(buf_vld),
      .in_ready(buf_rdy),
      .in_data({8'h00, buf_dat}),
      .out_valid(pat_valid),
      .out_ready(pat_ready),
      .out_data(pat_word)
   );
   assign pat_data = pat_word[7:0];
endmodule // msrc_engine
`default_nettype wire

// ==== msrc_engine_sva.sv ====
// assertion checker for the macro service engine ports
`timescale 1ns/10ps
`default_nettype none
`include "msrc_consts.vh"
module msrc_chk (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // setup and cpu side
   input wire logic start_load,
   input wire logic [7:0] mode_word,
   input wire logic instr_done,
   input wire logic [4:0] instr_class,
   input wire logic soft_int_req,
   input wire logic soft_int_ok,
   input wire logic irq_ack_ok,
   // transfer side
   input wire logic mem_rd,
   input wire logic cmp_wr,
   input wire logic pat_valid,
   input wire logic pat_ready,
   input wire logic [7:0] pat_data,
   input wire logic transfer_service_mode_bit,
   input wire logic vectored_irq,
   input wire logic request_flag_clr,
   input wire logic [15:0] transfer_count
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   // deferring classes; bit tests and carry ops are left out on purpose
   wire defer = instr_done && ((instr_class >= 5'h01 &&
      instr_class <= 5'h08) || instr_class == 5'h0A);
   chk_hold_off_eight: assert property (
      defer |=> !irq_ack_ok [*8]) else $error("no hold-off");
   chk_soft_int_pass: assert property (
      soft_int_req |-> soft_int_ok) else $error("soft int held");
   chk_write_after_read: assert property (
      cmp_wr |-> $past(mem_rd, 2)) else $error("compare write early");
   chk_count_step: assert property (
      !$past(start_load) && transfer_count != $past(transfer_count) |->
      transfer_count == $past(transfer_count) - 16'h0001)
      else $error("count not stepped by one");
   chk_mode_clear: assert property (
      $fell(transfer_service_mode_bit) |-> transfer_count == 16'h0000)
      else $error("mode bit cleared early");
   chk_irq_at_zero: assert property (
      vectored_irq |-> transfer_count == 16'h0000 &&
      !transfer_service_mode_bit) else $error("irq not at zero");
   chk_flag_clear: assert property (
      request_flag_clr |-> !mode_word[`MSRC_MODE_INT_BIT] &&
      transfer_count == 16'h0000)
      else $error("flag clear wrong");
   chk_pattern_hold: assert property (
      pat_valid && !pat_ready |=> pat_valid && $stable(pat_data))
      else $error("pattern dropped in stall");
endmodule // msrc_chk
bind msrc_engine msrc_chk chk_u (.mclk, .rst_n, .start_load, .mode_word,
   .instr_done, .instr_class, .soft_int_req, .soft_int_ok, .irq_ack_ok,
   .mem_rd, .cmp_wr, .pat_valid, .pat_ready, .pat_data,
   .transfer_service_mode_bit, .vectored_irq, .request_flag_clr,
   .transfer_count);
`default_nettype wire

// ==== msrc_far.sv ====
// far side model: byte memory, compare register and pattern sink
`timescale 1ns/10ps
`default_nettype none
module msrc_far (
   // clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // memory read port
   input wire logic mem_rd,
   input wire logic [19:0] mem_addr,
   output logic [15:0] mem_rdata,
   // compare register
   input wire logic cmp_wr,
   input wire logic [15:0] cmp_wdata,
   output logic [15:0] timer_compare_value,
   // sink, stalled on command
   input wire logic stall,
   output logic pat_ready
);
   logic [19:0] addr_q;
   logic [1:0] live_q;
   logic [15:0] junk_q;
   // byte at a is a[7:0]^a5; data lives two cycles, else a toggling pattern
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         live_q <= 2'h0;
         addr_q <= 20'h0_0000;
         junk_q <= 16'h0000;
         timer_compare_value <= 16'h1000;
      end else begin
         live_q <= mem_rd ? 2'h2 : live_q - (live_q != 2'h0);
         if (mem_rd) addr_q <= mem_addr;
         junk_q <= ~mem_rdata;
         if (cmp_wr) timer_compare_value <= cmp_wdata;
      end
   end
   assign mem_rdata = (live_q != 2'h0) ?
      {addr_q[7:0] + 8'h01, addr_q[7:0]} ^ 16'hA5A5 : junk_q;
   assign pat_ready = !stall;
endmodule // msrc_far
`default_nettype wire

// ==== msrc_engine_tb.sv ====
// self-checking bench for the macro service engine
`timescale 1ns/10ps
`default_nettype none
module msrc_engine_tb;
   logic mclk = 1'b0, rst_n = 1'b0, start_load = 1'b0, relocate_high = 1'b0;
   logic service_req = 1'b0, stall = 1'b0, instr_done = 1'b0;
   logic soft_int_req = 1'b0, irq_pending = 1'b0;
   logic pat_ready, mem_rd, cmp_wr, pat_valid, service_busy, irq_ack_ok;
   logic soft_int_ok, block_suspend, transfer_service_mode_bit;
   logic vectored_irq, request_flag_clr, block_resume;
   logic [7:0] mode_word = 8'h00, channel_pointer = 8'h5A, ring_length_reg;
   logic [7:0] ring_step_init, pat_data, ring_step_counter, cmp_target;
   logic [7:0] pat_target;
   logic [4:0] instr_class = 5'h00;
   logic [15:0] transfer_count_init = 16'h0000, mem_rdata, cmp_wdata;
   logic [15:0] timer_compare_value, transfer_count, cmp_e = 16'h1000;
   logic [19:0] mem_addr, channel_addr, timer_data_ptr_now;
   logic [19:0] pattern_data_ptr_now;
   logic [7:0] pq[$], pe[$];
   int num_errors = 0, checks_done = 0, rd_cnt = 0, k, c;
   int n_irq = 0, n_clr = 0, n_res = 0;
   msrc_engine dut_u (.mclk, .rst_n, .start_load, .mode_word,
      .channel_pointer, .timer_data_pointer_init(20'h0_1000),
      .pattern_data_pointer_init(20'h0_2010), .transfer_count_init,
      .ring_length_reg, .ring_step_init, .timer_target_pointer(8'h52),
      .pattern_target_pointer(8'h98), .relocate_high, .service_req,
      .service_busy, .mem_rd, .mem_addr, .mem_rdata, .timer_compare_value,
      .cmp_wr, .cmp_wdata, .cmp_target, .pat_valid, .pat_ready, .pat_data,
      .pat_target, .transfer_service_mode_bit, .vectored_irq,
      .request_flag_clr, .channel_addr, .instr_done, .instr_class,
      .soft_int_req, .irq_pending, .irq_ack_ok, .soft_int_ok, .block_suspend,
      .block_resume, .transfer_count, .ring_step_counter,
      .timer_data_ptr_now, .pattern_data_ptr_now);
   msrc_far far_u (.mclk, .rst_n, .mem_rd, .mem_addr, .mem_rdata, .cmp_wr,
      .cmp_wdata, .timer_compare_value, .stall, .pat_ready);
   // clock and a monitor of accepted patterns, memory reads and pulses
   initial forever #50 mclk = ~mclk;
   always @(posedge mclk) begin
      if (pat_valid && pat_ready) pq.push_back(pat_data);
      if (mem_rd) rd_cnt++;
      if (vectored_irq) n_irq++;
      if (request_flag_clr) n_clr++;
      if (block_resume) n_res++;
   end
   function automatic logic [7:0] bt(input logic [19:0] a);
      return a[7:0] ^ 8'hA5;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic load(input logic [7:0] m, input logic [15:0] n,
         input logic [7:0] r);
      mode_word = m;
      transfer_count_init = n;
      ring_length_reg = r;
      ring_step_init = r;
      start_load = 1'b1;
      step(1);
      start_load = 1'b0;
      step(1);
   endtask
   // one request; waits are bounded so a dead engine cannot hang us
   task automatic svc(input logic [15:0] ecmp);
      int i;
      service_req = 1'b1;
      step(1);
      service_req = 1'b0;
      for (i = 0; i < 40 && cmp_wr !== 1'b1; i++) step(1);
      chk(cmp_wdata, ecmp);
      for (i = 0; i < 60 && service_busy !== 1'b0; i++) step(1);
   endtask
   task automatic drain;
      step(8);
      chk(pq.size(), pe.size());
      while (pe.size() > 0) chk(pq.pop_front(), pe.pop_front());
      pq.delete();
   endtask
   task automatic results;
      $display("checks %0d mismatches %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      #1_500_000;
      num_errors++;
      results;
   end
   initial begin
      step(3);
      rst_n = 1'b1;
      step(1);
      // increment mode, ring of two, sink stalled until the buffer is full
      load(8'h7F, 16'h0003, 8'h02);
      chk(cmp_target, 8'h52);
      chk(pat_target, 8'h98);
      stall = 1'b1;
      for (k = 0; k < 3; k++) begin
         if (k == 2) chk(pat_valid, 1'b1);
         if (k == 2) stall = 1'b0;
         cmp_e = cmp_e + {bt(20'h0_1001 + 2 * k), bt(20'h0_1000 + 2 * k)};
         pe.push_back(bt(20'h0_2010 + k % 2));
         svc(cmp_e);
         chk(transfer_count, 16'h0002 - k);
      end
      drain;
      chk(transfer_service_mode_bit, 1'b0);
      chk(n_irq, 1);
      chk(ring_step_counter, 8'h01);
      chk(pattern_data_ptr_now, 20'h0_2011);
      chk(timer_data_ptr_now, 20'h0_1006);
      $display("test done: ring with addition");
      // held timer pointer, falling data pointer, one-byte delta
      load(8'h3C, 16'h0002, 8'h08);
      for (k = 0; k < 2; k++) begin
         cmp_e = cmp_e + {8'h00, bt(20'h0_1000)};
         pe.push_back(bt(20'h0_2010 - k));
         svc(cmp_e);
         chk(timer_data_ptr_now, 20'h0_1000);
      end
      drain;
      chk(pattern_data_ptr_now, 20'h0_200E);
      chk(ring_step_counter, 8'h06);
      $display("test done: held timer pointer");
      // plain copy without vectored irq, then a late request is ignored
      load(8'h73, 16'h0001, 8'h02);
      pe.push_back(bt(20'h0_2010));
      svc({bt(20'h0_1001), bt(20'h0_1000)});
      drain;
      chk(n_clr, 1);
      chk(n_irq, 2);
      service_req = 1'b1;
      step(2);
      service_req = 1'b0;
      chk(service_busy, 1'b0);
      chk(transfer_count, 16'h0000);
      $display("test done: copy and refusal");
      // counter mode in the relocated channel area
      relocate_high = 1'b1;
      channel_pointer = 8'h7E;
      c = rd_cnt;
      load(8'h00, 16'h0002, 8'h00);
      chk(channel_addr, 20'hF_FE7E);
      for (k = 0; k < 2; k++) begin
         service_req = 1'b1;
         step(1);
         service_req = 1'b0;
         step(4);
         chk(transfer_count, 16'h0001 - k);
      end
      chk(rd_cnt, c);
      chk(transfer_service_mode_bit, 1'b0);
      chk(n_irq, 3);
      $display("test done: counter mode");
      // every instruction class: suspension, hold-off and soft interrupts
      for (c = 0; c < 16; c++) begin
         instr_class = c[4:0];
         instr_done = 1'b1;
         soft_int_req = 1'b1;
         irq_pending = 1'b1;
         step(1);
         instr_done = 1'b0;
         chk(block_suspend, c == 14 || c == 15);
         chk(irq_ack_ok, !((c >= 1 && c <= 8) || c == 10));
         chk(soft_int_ok, 1'b1);
         soft_int_req = 1'b0;
         irq_pending = 1'b0;
         step(9);
         chk(irq_ack_ok, 1'b1);
      end
      // the last block instruction is still open: a service resumes it
      load(8'h00, 16'h0001, 8'h00);
      service_req = 1'b1;
      step(1);
      service_req = 1'b0;
      step(4);
      chk(n_res, 1);
      $display("test done: instruction classes");
      results;
   end
endmodule // msrc_engine_tb
`default_nettype wire
